/* File: rtl/scan_gate_controller.sv */
// Function
// - Continuous mode sends each decode ungated that arrives while the sender is idle.
// - Buffered data change suppresses repeated label.
// - Hardware gate: reads only while open, one send.
// - Host start/stop strings open and close gate.
// - High speed: trigger outputs, never send label.
// - Tracking on in a gated mode: laser follows gate.
// - Tracking off: laser always on.
// - Send on read, or hold until close.
// - Start string up to two chars, default SI.
// - Stop string up to two chars, default ETX.
// - ACK/NAK: await host answer, ACK releases.
// - NAK or timeout resends same label.
// - At most five resends, then give up.
// - ACK/NAK timeout 0 to 9999 ms.
// - Timeout after label leaves re-arms same label.
// - Data change timeout 0 to 30000 ms.
// - Gate valid after 1 to 999 ms debounce.
// - Gate timeout closes gate, sends label or no-read.
// - Running gate timer ignores gate input.
// - Each gate open reloads gate timer.
// - Mux framing: open, label, close messages.
// - Compare enable compares labels to compare string.
module scan_gate_controller
  import scan_gate_pkg::*;
#(
  parameter int LABEL_W     = 32,
  parameter int TICK_CYCLES_P = scan_gate_pkg::TICK_CYCLES
) (
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  input  wire logic               clk_en,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [15:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [15:0]        reg_rdata,
  input  wire logic               gate_in,
  input  wire logic               dec_valid,
  input  wire logic [LABEL_W-1:0] dec_label,
  input  wire logic               label_present,
  input  wire logic               rx_valid,
  input  wire logic [7:0]         rx_char,
  output logic                    tx_valid,
  output logic      [7:0]         tx_char,
  input  wire logic               tx_ready,
  output logic                    send_label,
  output logic                    send_noread,
  output logic      [LABEL_W-1:0] label_out,
  output logic                    send_match,
  input  wire logic               send_done,
  output logic                    trigger,
  output logic                    laser_en
);
  import scan_gate_pkg::*;

  // Elaboration check: compare field and tick counter must fit.
  if (LABEL_W < 16 || TICK_CYCLES_P < 2 || TICK_CYCLES_P > 2**24) begin : g_bad_param
    $error("scan_gate_controller: unsupported parameter value");
  end

  // Clamp a written value into a programmable range.
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  // One or two character string match; a zero upper byte means one character.
  function automatic logic str_hit(input logic [15:0] s, input logic [7:0] prev,
                                   input logic [7:0] cur);
    str_hit = (s[15:8] == 8'h00) ? (cur == s[7:0]) : (prev == s[15:8] && cur == s[7:0]);
  endfunction : str_hit

  // Millisecond down-counter step: count down on tick, hold at zero; callers do the reload.
  function automatic logic [15:0] ms_step(input logic [15:0] cnt, input logic tk);
    ms_step = (tk && cnt != 16'h0000) ? cnt - 16'h0001 : cnt;
  endfunction : ms_step

  // Multiplexor framing characters, index 0 to 3.
  function automatic logic [7:0] frame_char(input logic closing, input logic [1:0] idx);
    unique case (idx)
      2'd0: frame_char = CH_STX;
      2'd1: frame_char = closing ? CH_SO : CH_SI;
      2'd2: frame_char = CH_CAN;
      2'd3: frame_char = CH_CR;
    endcase
  endfunction : frame_char

  logic [23:0]    tick_cnt_reg;
  logic           tick_reg;
  logic           gate_meta_reg, gate_sync_reg;
  logic [7:0]     ctrl_reg;
  logic [15:0]    start_str_reg, stop_str_reg, ack_to_reg, dc_to_reg, deb_reg, gto_reg;
  logic [15:0]    cmp_reg;
  logic [15:0]    deb_cnt_reg, gto_cnt_reg, dc_cnt_reg, ack_cnt_reg;
  logic           gto_run_reg, wait_release_reg, sw_level_reg, gate_open_reg;
  logic [7:0]     prev_rx_reg;
  logic           have_label_reg, sent_reg, last_valid_reg, present_q_reg, dc_run_reg;
  logic [LABEL_W-1:0] hold_label_reg, last_label_reg, cur_label_reg;
  logic           cur_noread_reg;
  logic [2:0]     attempts_reg;
  logic [7:0]     giveup_cnt_reg;
  logic [1:0]     idx_reg, idx_next;
  send_state_type state_reg, state_next;

  wire [2:0] mode    = ctrl_reg[MODE_LSB +: 3];
  wire       track   = ctrl_reg[TRACK_BIT];
  wire       on_read = ctrl_reg[ON_READ_BIT];
  wire       acknak  = ctrl_reg[ACKNAK_BIT];
  wire       mux_en  = ctrl_reg[MUX_BIT];
  wire       gated   = (mode == MODE_HW_GATE) || (mode == MODE_SW_GATE) ||
                       (mode == MODE_HSPEED);
  wire [15:0] deb_eff = (deb_reg == 16'h0000) ? DEBOUNCE_MIN : deb_reg;

  // Millisecond tick; every timer below counts this tick only.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_reg <= 24'h000000;
      tick_reg     <= 1'b0;
    end else if (clk_en) begin
      tick_reg     <= (tick_cnt_reg == 24'(TICK_CYCLES_P - 1));
      tick_cnt_reg <= (tick_cnt_reg == 24'(TICK_CYCLES_P - 1)) ? 24'h000000
                                                             : tick_cnt_reg + 24'h000001;
    end
  end

  // Gate pin synchroniser; only the second stage is read.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gate_meta_reg <= 1'b0;
      gate_sync_reg <= 1'b0;
    end else if (clk_en) begin
      gate_meta_reg <= gate_in;
      gate_sync_reg <= gate_meta_reg;
    end
  end

  // Register writes; range limits are enforced here so software cannot overrun a timer.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg      <= CTRL_RST;
      start_str_reg <= START_STR_RST;
      stop_str_reg  <= STOP_STR_RST;
      ack_to_reg    <= ACK_TO_RST;
      dc_to_reg     <= DC_TO_RST;
      deb_reg       <= DEBOUNCE_RST;
      gto_reg       <= GATE_TO_RST;
      cmp_reg       <= 16'h0000;
    end else if (clk_en && reg_wr) begin
      unique case (reg_addr)
        CTRL_OFS:      ctrl_reg      <= reg_wdata[7:0];
        START_STR_OFS: start_str_reg <= reg_wdata;
        STOP_STR_OFS:  stop_str_reg  <= reg_wdata;
        ACK_TO_OFS:    ack_to_reg    <= clamp(reg_wdata, 16'h0000, ACK_TO_MAX);
        DC_TO_OFS:     dc_to_reg     <= clamp(reg_wdata, 16'h0000, DC_TO_MAX);
        DEBOUNCE_OFS:  deb_reg       <= clamp(reg_wdata, DEBOUNCE_MIN, DEBOUNCE_MAX);
        GATE_TO_OFS:   gto_reg       <= clamp(reg_wdata, 16'h0000, GATE_TO_MAX);
        COMPARE_OFS:   cmp_reg       <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Register reads; unmapped offsets read zero.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      if (reg_rd) begin
        unique case (reg_addr)
          CTRL_OFS:      reg_rdata <= {8'h00, ctrl_reg};
          START_STR_OFS: reg_rdata <= start_str_reg;
          STOP_STR_OFS:  reg_rdata <= stop_str_reg;
          ACK_TO_OFS:    reg_rdata <= ack_to_reg;
          DC_TO_OFS:     reg_rdata <= dc_to_reg;
          DEBOUNCE_OFS:  reg_rdata <= deb_reg;
          GATE_TO_OFS:   reg_rdata <= gto_reg;
          COMPARE_OFS:   reg_rdata <= cmp_reg;
          STATUS_OFS:    reg_rdata <= {giveup_cnt_reg, 1'b0, attempts_reg, have_label_reg,
                                       state_reg != S_IDLE, laser_en, gate_open_reg};
          default:       reg_rdata <= 16'h0000;
        endcase
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  // Debounce: the synchronised gate must stay high for the programmed time.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      deb_cnt_reg <= 16'h0000;
    end else if (clk_en) begin
      if (!gate_sync_reg) begin
        deb_cnt_reg <= 16'h0000;
      end else if (tick_reg && deb_cnt_reg < deb_eff) begin
        deb_cnt_reg <= deb_cnt_reg + 16'h0001;
      end
    end
  end
  wire hw_level = gate_sync_reg && (deb_cnt_reg >= deb_eff);

  // Host start and stop strings drive the software gate level.
  wire start_hit = rx_valid && str_hit(start_str_reg, prev_rx_reg, rx_char);
  wire stop_hit  = rx_valid && str_hit(stop_str_reg, prev_rx_reg, rx_char);
  wire gate_req  = (mode == MODE_SW_GATE) ? sw_level_reg : hw_level;
  wire gto_fire  = gto_run_reg && tick_reg && (gto_cnt_reg == 16'h0001);
  wire gate_open_evt  = gated && !gate_open_reg && !wait_release_reg && gate_req;
  // While the gate timer runs the gate request is not looked at.
  wire gate_close_evt = gate_open_reg && (gto_run_reg ? gto_fire : !gate_req);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prev_rx_reg  <= 8'h00;
      sw_level_reg <= 1'b0;
    end else if (clk_en) begin
      if (rx_valid) begin
        prev_rx_reg <= rx_char;
      end
      if (mode != MODE_SW_GATE || stop_hit || gto_fire) begin
        sw_level_reg <= 1'b0;
      end else if (start_hit) begin
        sw_level_reg <= 1'b1;
      end
    end
  end

  // Gate state and gate timeout; a timeout close waits for the request to drop.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gate_open_reg    <= 1'b0;
      gto_cnt_reg      <= 16'h0000;
      gto_run_reg      <= 1'b0;
      wait_release_reg <= 1'b0;
    end else if (clk_en) begin
      if (!gated) begin
        gate_open_reg <= 1'b0;
        gto_run_reg   <= 1'b0;
      end else if (gate_open_evt) begin
        gate_open_reg <= 1'b1;
        gto_cnt_reg   <= gto_reg;
        gto_run_reg   <= (gto_reg != 16'h0000);
      end else if (gate_close_evt) begin
        gate_open_reg <= 1'b0;
        gto_run_reg   <= 1'b0;
      end else begin
        gto_cnt_reg <= ms_step(gto_cnt_reg, tick_reg);
      end
      wait_release_reg <= gto_fire ? 1'b1 : (wait_release_reg && gate_req);
    end
  end

  // Laser follows the gate only with tracking on in a gated mode.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      laser_en <= 1'b1;
    end else if (clk_en) begin
      laser_en <= !track || !gated || gate_open_reg;
    end
  end

  // Per-gate label capture and one-send bookkeeping.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      have_label_reg <= 1'b0;
      sent_reg       <= 1'b0;
      hold_label_reg <= '0;
    end else if (clk_en) begin
      if (gate_open_evt) begin
        have_label_reg <= 1'b0;
        sent_reg       <= 1'b0;
      end else if (dec_valid && gate_open_reg && !have_label_reg) begin
        have_label_reg <= 1'b1;
        hold_label_reg <= dec_label;
        sent_reg       <= on_read;
      end
    end
  end

  // Data change memory and the re-arm timer started when the label leaves.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      last_valid_reg <= 1'b0;
      last_label_reg <= '0;
      present_q_reg  <= 1'b0;
      dc_run_reg     <= 1'b0;
      dc_cnt_reg     <= 16'h0000;
    end else if (clk_en) begin
      present_q_reg <= label_present;
      if (dec_valid && (mode == MODE_DC_BUF || mode == MODE_DC_TO)) begin
        last_valid_reg <= 1'b1;
        last_label_reg <= dec_label;
        dc_run_reg     <= 1'b0;
      end else if (mode == MODE_DC_TO && present_q_reg && !label_present) begin
        dc_cnt_reg     <= dc_to_reg;
        dc_run_reg     <= (dc_to_reg != 16'h0000);
        last_valid_reg <= (dc_to_reg != 16'h0000) && last_valid_reg;
      end else if (dc_run_reg && tick_reg && dc_cnt_reg == 16'h0001) begin
        dc_run_reg     <= 1'b0;
        last_valid_reg <= 1'b0;
      end else if (dc_run_reg) begin
        dc_cnt_reg <= ms_step(dc_cnt_reg, tick_reg);
      end
    end
  end

  // Send request: which event asks for a transmission in each mode.
  logic               req_fire, req_noread;
  logic [LABEL_W-1:0] req_label;
  always_comb begin
    req_fire   = 1'b0;
    req_noread = 1'b0;
    req_label  = dec_label;
    unique case (mode)
      MODE_CONT: req_fire = dec_valid;
      MODE_DC_BUF, MODE_DC_TO:
        req_fire = dec_valid && (!last_valid_reg || dec_label != last_label_reg);
      MODE_HW_GATE, MODE_SW_GATE, MODE_HSPEED: begin
        if (gate_close_evt && !sent_reg) begin
          req_fire   = 1'b1;
          req_noread = !have_label_reg;
          req_label  = hold_label_reg;
        end else if (on_read && dec_valid && gate_open_reg && !have_label_reg) begin
          req_fire = 1'b1;
        end
      end
      default: ;
    endcase
  end
  wire send_fire = req_fire && (mode != MODE_HSPEED);

  // High speed mode pulses the outputs instead of sending.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trigger <= 1'b0;
    end else if (clk_en) begin
      trigger <= req_fire && !req_noread && (mode == MODE_HSPEED);
    end
  end

  // Transmit sequencer next state.
  wire tx_take  = tx_valid && tx_ready;
  wire ack_hit  = rx_valid && (rx_char == CH_ACK);
  wire nak_hit  = rx_valid && (rx_char == CH_NAK);
  wire ack_tmo  = (ack_to_reg != 16'h0000) && tick_reg && (ack_cnt_reg == 16'h0001);
  wire need_ack = acknak && !cur_noread_reg;
  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    unique case (state_reg)
      S_IDLE: begin
        idx_next = 2'd0;
        if (send_fire) begin
          state_next = mux_en ? S_OPEN : S_LABEL;
        end
      end
      S_OPEN, S_CLOSE: begin
        if (tx_take) begin
          idx_next = idx_reg + 2'd1;
          if (idx_reg == 2'd3) begin
            state_next = (state_reg == S_CLOSE) ? (need_ack ? S_WAIT : S_IDLE) : S_LABEL;
          end
        end
      end
      S_LABEL: begin
        if (send_done && !send_label) begin
          state_next = mux_en ? S_CLOSE : (need_ack ? S_WAIT : S_IDLE);
        end
      end
      S_WAIT: begin
        if (ack_hit) begin
          state_next = S_IDLE;
        end else if ((nak_hit || ack_tmo) && attempts_reg < RESEND_MAX) begin
          state_next = mux_en ? S_OPEN : S_LABEL;
        end else if (nak_hit || ack_tmo) begin
          state_next = S_IDLE;
        end
      end
    endcase
  end

  // Sequencer state, resend count and the ACK/NAK timer.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg      <= S_IDLE;
      idx_reg        <= 2'd0;
      attempts_reg   <= 3'd0;
      giveup_cnt_reg <= 8'h00;
      ack_cnt_reg    <= 16'h0000;
      cur_label_reg  <= '0;
      cur_noread_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      if (state_reg == S_IDLE && send_fire) begin
        cur_label_reg  <= req_label;
        cur_noread_reg <= req_noread;
        attempts_reg   <= 3'd0;
      end else if (state_reg == S_WAIT && state_next != S_WAIT && !ack_hit) begin
        attempts_reg <= (state_next == S_IDLE) ? attempts_reg : attempts_reg + 3'd1;
        giveup_cnt_reg <= (state_next == S_IDLE) ? giveup_cnt_reg + 8'h01 : giveup_cnt_reg;
      end
      ack_cnt_reg <= (state_reg != S_WAIT) ? ack_to_reg : ms_step(ack_cnt_reg, tick_reg);
    end
  end

  // Registered outputs towards the host port and the formatter.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_valid    <= 1'b0;
      tx_char     <= 8'h00;
      send_label  <= 1'b0;
      send_noread <= 1'b0;
      label_out   <= '0;
      send_match  <= 1'b0;
    end else if (clk_en) begin
      tx_valid   <= (state_next == S_OPEN) || (state_next == S_CLOSE);
      tx_char    <= frame_char(state_next == S_CLOSE, idx_next);
      send_label <= (state_next == S_LABEL) && (state_reg != S_LABEL);
      if (state_reg == S_IDLE && send_fire) begin
        label_out   <= req_label;
        send_noread <= req_noread;
        send_match  <= ctrl_reg[COMPARE_BIT] && !req_noread &&
                       (req_label[15:0] == cmp_reg);
      end
    end
  end

  // Checks. A NAK inside the resend budget must restart the send.
  sequence s_nak_in_budget;
    clk_en && state_reg == S_WAIT && nak_hit && !ack_hit && attempts_reg < RESEND_MAX;
  endsequence
  sequence s_resend_start;
    state_reg == S_OPEN || state_reg == S_LABEL;
  endsequence

  AST_CONT_SEND: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && mode == MODE_CONT && dec_valid && state_reg == S_IDLE |=> state_reg != S_IDLE)
    else $error("continuous decode not sent");
  AST_HS_NO_LABEL: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && mode == MODE_HSPEED && state_reg == S_IDLE |=> !send_label)
    else $error("label sent in high speed mode");
  AST_LASER_ON: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && !track |=> laser_en)
    else $error("laser off without tracking");
  AST_LASER_TRACK: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && track && gated |=> laser_en == $past(gate_open_reg))
    else $error("laser does not follow gate");
  AST_DEBOUNCE: assert property (@(posedge sys_clk) disable iff (!rstn)
    gate_open_evt && mode == MODE_HW_GATE |-> gate_sync_reg && deb_cnt_reg >= deb_eff)
    else $error("gate opened before debounce");
  AST_GATE_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && gated && gate_open_reg && gto_run_reg && !gto_fire |=> gate_open_reg)
    else $error("gate closed while timer ran");
  AST_ONE_SEND: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && gated && req_fire |-> !sent_reg)
    else $error("second send in one gate");
  AST_ACK_RELEASE: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && state_reg == S_WAIT && ack_hit |=> state_reg == S_IDLE)
    else $error("ack did not release sender");
  AST_NAK_RESEND: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_nak_in_budget |=> s_resend_start)
    else $error("nak did not resend");
  AST_RESEND_LIMIT: assert property (@(posedge sys_clk) disable iff (!rstn)
    attempts_reg <= RESEND_MAX)
    else $error("too many resends");
  AST_FRAME_START: assert property (@(posedge sys_clk) disable iff (!rstn)
    clk_en && state_reg == S_IDLE && state_next == S_OPEN |=> tx_valid && tx_char == CH_STX)
    else $error("framing does not open with STX");
endmodule : scan_gate_controller

/* File: rtl/scan_gate_pkg.sv */
package scan_gate_pkg;
  // Register byte offsets on the plain register port.
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] START_STR_OFS  = 8'h04;
  localparam logic [7:0] STOP_STR_OFS   = 8'h08;
  localparam logic [7:0] ACK_TO_OFS     = 8'h0c;
  localparam logic [7:0] DC_TO_OFS      = 8'h10;
  localparam logic [7:0] DEBOUNCE_OFS   = 8'h14;
  localparam logic [7:0] GATE_TO_OFS    = 8'h18;
  localparam logic [7:0] COMPARE_OFS    = 8'h1c;
  localparam logic [7:0] STATUS_OFS     = 8'h20;
  // Control field positions.
  localparam int MODE_LSB     = 0;
  localparam int TRACK_BIT    = 3;
  localparam int ON_READ_BIT  = 4;
  localparam int ACKNAK_BIT   = 5;
  localparam int MUX_BIT      = 6;
  localparam int COMPARE_BIT  = 7;
  // Operating modes held in the mode field.
  localparam logic [2:0] MODE_CONT    = 3'h0;
  localparam logic [2:0] MODE_DC_BUF  = 3'h1;
  localparam logic [2:0] MODE_HW_GATE = 3'h2;
  localparam logic [2:0] MODE_SW_GATE = 3'h3;
  localparam logic [2:0] MODE_HSPEED  = 3'h4;
  localparam logic [2:0] MODE_DC_TO   = 3'h5;
  // Reset values.
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [15:0] START_STR_RST = 16'h000f;
  localparam logic [15:0] STOP_STR_RST  = 16'h0003;
  localparam logic [15:0] ACK_TO_RST    = 16'h0000;
  localparam logic [15:0] DC_TO_RST     = 16'h0000;
  localparam logic [15:0] DEBOUNCE_RST  = 16'h0001;
  localparam logic [15:0] GATE_TO_RST   = 16'h0000;
  // Programmable ranges in milliseconds, and the resend limit.
  localparam logic [15:0] ACK_TO_MAX    = 16'd9999;
  localparam logic [15:0] DC_TO_MAX     = 16'd30000;
  localparam logic [15:0] GATE_TO_MAX   = 16'd30000;
  localparam logic [15:0] DEBOUNCE_MIN  = 16'd1;
  localparam logic [15:0] DEBOUNCE_MAX  = 16'd999;
  localparam logic [2:0]  RESEND_MAX    = 3'd5;
  // Host control characters.
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_SI  = 8'h0f;
  localparam logic [7:0] CH_SO  = 8'h0e;
  localparam logic [7:0] CH_CAN = 8'h18;
  localparam logic [7:0] CH_CR  = 8'h0d;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_NAK = 8'h15;
  // Millisecond tick derived from the 100 MHz system clock.
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  // Transmit sequencer states.
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_OPEN  = 5'b00010,
    S_LABEL = 5'b00100,
    S_CLOSE = 5'b01000,
    S_WAIT  = 5'b10000
  } send_state_type;
endpackage : scan_gate_pkg

/* File: dv/host_model.sv */
module host_model (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_char,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_char
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [$];
  // Slow mode stalls every other cycle, so the sender must hold a character.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) tx_ready <= 1'b0;
    else tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // A character counts only at an edge where valid and ready are both high.
  always @(posedge sys_clk) begin
    if (rstn && tx_valid && tx_ready) got.push_back(tx_char);
  end
  // The host line rests idle until the bench asks for an answer.
  initial begin
    rx_valid = 1'b0;
    rx_char  = 8'hff;
  end
  // One received character strobe; afterwards the line shows the inverse.
  task automatic say(input logic [7:0] ch);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_char  <= ch;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_char  <= ~ch;
  endtask : say
endmodule : host_model

/* File: dv/scan_gate_controller_tb.sv */
module scan_gate_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scan_gate_pkg::*;
  logic        sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        gate_in = 1'b0, dec_valid = 1'b0, send_done = 1'b0, slow = 1'b0;
  logic        tx_ready, rx_valid, tx_valid, send_label, send_noread;
  logic        send_match, trigger, laser_en, hit;
  logic        label_present = 1'b0, trig_seen = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  rx_char, tx_char;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [31:0] dec_label = 32'h0, label_out;
  logic [7:0]  frm [8] = '{CH_STX, CH_SI, CH_CAN, CH_CR, CH_STX, CH_SO, CH_CAN, CH_CR};
  int          err_total = 0;
  int          n_checks = 0;
  always #5 sys_clk = ~sys_clk;
  // The label formatter answers one cycle after each send request.
  always @(posedge sys_clk) send_done <= send_label;
  // The trigger is a one-cycle pulse, so it is latched for a later compare.
  always @(posedge sys_clk) if (trigger === 1'b1) trig_seen <= 1'b1;
  scan_gate_controller #(.LABEL_W(32), .TICK_CYCLES_P(10)) i_scan_gate_controller (
    .sys_clk, .rstn, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .gate_in, .dec_valid, .dec_label, .label_present, .rx_valid,
    .rx_char, .tx_valid, .tx_char, .tx_ready, .send_label, .send_noread, .label_out,
    .send_match, .send_done, .trigger, .laser_en);
  host_model i_host_model (.sys_clk, .rstn, .slow, .tx_valid, .tx_char, .tx_ready,
    .rx_valid, .rx_char);
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample just then.
  task rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, {16'h0, exp}, {16'h0, reg_rdata});
  endtask : rd
  // One decode, then a bounded watch for the send pulse.
  task dec(input logic [31:0] v);
    @(posedge sys_clk);
    dec_valid <= 1'b1;
    dec_label <= v;
    @(posedge sys_clk);
    dec_valid <= 1'b0;
    hit = 1'b0;
    for (int i = 0; i < 60 && !hit; i++) begin
      #1 hit = (send_label === 1'b1);
      @(posedge sys_clk);
    end
  endtask : dec
  task wrap_up();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(CTRL_OFS, 16'h0000, "ctrl");
    rd(START_STR_OFS, 16'h000f, "start");
    rd(STOP_STR_OFS, 16'h0003, "stop");
    rd(8'h3c, 16'h0000, "unmapped");
    wr(ACK_TO_OFS, 16'hffff);
    rd(ACK_TO_OFS, 16'd9999, "ack_to");
    wr(DC_TO_OFS, 16'hffff);
    rd(DC_TO_OFS, 16'd30000, "dc_to");
    wr(DEBOUNCE_OFS, 16'h0000);
    rd(DEBOUNCE_OFS, 16'h0001, "debounce");
    chk("laser_en", 1, laser_en);
    dec(32'h1234_5678);
    chk("label_out", 32'h1234_5678, label_out);
    dec(32'h1234_5678);
    chk("repeat sent", 1, hit);
    wr(CTRL_OFS, 16'h0001);
    dec(32'h0000_00aa);
    chk("new sent", 1, hit);
    dec(32'h0000_00aa);
    chk("same held", 0, hit);
    wr(CTRL_OFS, 16'h0040);
    slow <= 1'b1;
    i_host_model.got.delete();
    dec(32'h0000_00c3);
    repeat (40) @(posedge sys_clk);
    chk("frames", 8, i_host_model.got.size());
    for (int k = 0; k < 8; k++) chk("frame", {24'h0, frm[k]}, i_host_model.got[k]);
    wr(CTRL_OFS, 16'h001a);
    repeat (3) @(posedge sys_clk);
    chk("laser closed", 0, laser_en);
    gate_in <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk("laser open", 1, laser_en);
    dec(32'h0000_0077);
    chk("gate read", 1, hit);
    dec(32'h0000_0078);
    chk("one per gate", 0, hit);
    gate_in <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk("laser off", 0, laser_en);
    // High speed: a decode in the gate pulses the trigger and sends nothing.
    wr(CTRL_OFS, 16'h0014);
    gate_in <= 1'b1;
    repeat (40) @(posedge sys_clk);
    dec(32'h0000_0099);
    chk("hs label", 0, hit);
    chk("trigger", 1, trig_seen);
    gate_in <= 1'b0;
    // Host strings gate the reads; a gate closed empty ends in a no-read.
    wr(CTRL_OFS, 16'h0013);
    i_host_model.say(CH_SI);
    rd(STATUS_OFS, 16'h0003, "sw open");
    i_host_model.say(STOP_STR_RST[7:0]);
    repeat (3) @(posedge sys_clk);
    chk("no-read", 1, send_noread);
    rd(STATUS_OFS, 16'h0002, "sw closed");
    // Data change with timeout: a label that left is new after the timer.
    wr(DC_TO_OFS, 16'h0002);
    wr(CTRL_OFS, 16'h0005);
    label_present <= 1'b1;
    dec(32'h0000_00bb);
    chk("dc new", 1, hit);
    dec(32'h0000_00bb);
    chk("dc held", 0, hit);
    label_present <= 1'b0;
    repeat (40) @(posedge sys_clk);
    dec(32'h0000_00bb);
    chk("dc re-armed", 1, hit);
    // Host confirmation: one NAK resends, ACK releases, six NAKs give up.
    wr(COMPARE_OFS, 16'h0055);
    wr(CTRL_OFS, 16'h00a0);
    dec(32'h0000_0055);
    chk("match", 1, send_match);
    i_host_model.say(CH_NAK);
    rd(STATUS_OFS, 16'h0016, "resend");
    i_host_model.say(CH_ACK);
    rd(STATUS_OFS, 16'h0012, "released");
    dec(32'h0000_0066);
    for (int k = 0; k < 6; k++) begin
      repeat (4) @(posedge sys_clk);
      i_host_model.say(CH_NAK);
    end
    rd(STATUS_OFS, 16'h0152, "give up");
    wrap_up();
  end
endmodule : scan_gate_controller_tb
